// ==== rtl/adb_map.svh ====
// Purpose: Constants of the converter board control block
// Assumes: Core clock of 125 MHz
// Notes: Definitions only; included by the top module
`ifndef ADB_MAP_SVH
`define ADB_MAP_SVH

// Clock and timing figures
`define ADB_CLK_MHZ 125
`define ADB_CONV_TIME_NS 1260
`define ADB_MAX_RATE_KHZ 500
`define ADB_MIN_RATE_SPS 4000
// Least times round up, longest times round down
`define ADB_CONV_CYC ((`ADB_CONV_TIME_NS * `ADB_CLK_MHZ + 999) / 1000)
`define ADB_MIN_PERIOD_CYC ((`ADB_CLK_MHZ * 1000 + `ADB_MAX_RATE_KHZ - 1) / `ADB_MAX_RATE_KHZ)
`define ADB_MAX_PERIOD_CYC ((`ADB_CLK_MHZ * 1000000) / `ADB_MIN_RATE_SPS)

// Host read addresses (channels 0 to 5 at 0 to 5)
`define ADB_RD_LAST_CH 3'h5
`define ADB_RD_STATUS 3'h6
// Host write addresses
`define ADB_WR_DAC_A 3'h0
`define ADB_WR_DAC_B 3'h1

// Status word bit positions
`define ADB_ST_EOC 0
`define ADB_ST_BUSY 1
`define ADB_ST_DAC_RDY 2

// Reset values
`define ADB_DAC_ZERO 16'h0000
`define ADB_DATA_IDLE 16'h0000

`endif

// ==== rtl/adb_pkg.sv ====
// Purpose: Types shared by the converter board control modules
// Assumes: Nothing beyond the constants header
// Notes: Enumerations carry no codes of their own
package adb_pkg;
  typedef enum logic [1:0] {ADB_SRC_OWN_CLOCK, ADB_SRC_TRIG_A, ADB_SRC_TRIG_B, ADB_SRC_EXT} adb_start_src_t;
  typedef enum logic [2:0] {ADB_UPD_SYNC_ADC, ADB_UPD_TRIG_A, ADB_UPD_TRIG_B, ADB_UPD_EXT, ADB_UPD_ON_WRITE}
    adb_dac_trig_t;
  typedef enum logic [1:0] {ADB_MUX_INPUTS, ADB_MUX_GROUND, ADB_MUX_REFERENCE, ADB_MUX_CAL} adb_mux_sel_t;
endpackage

// ==== rtl/adb_stream_if.sv ====
// Purpose: Valid/ready word stream between the block's own modules
// Assumes: Both ends on the core clock
// Notes: A word moves on a cycle with valid and ready both high
`timescale 1ns/100ps
interface adb_stream_if #(parameter int W = 17);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/adb_buf2.sv ====
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Full and empty are exact; a stalled drain side fills it
`timescale 1ns/100ps
module adb_buf2
  import adb_pkg::*;
#(
  parameter int W = 17
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  // Stream sides
  adb_stream_if.snk in_s,
  adb_stream_if.src out_s
);
  logic [W-1:0] mem [2];
  logic [1:0] count;
  logic wp;
  logic rp;
  logic push;
  logic pop;

  // Ready and valid follow the fill count alone, so no path runs through
  assign in_s.ready = (count != 2'h2);
  assign out_s.valid = (count != 2'h0);
  assign out_s.data = mem[rp];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count <= 2'h0;
      wp <= 1'b0;
      rp <= 1'b0;
    end
    else if (clr_i)
    begin
      count <= 2'h0;
      wp <= 1'b0;
      rp <= 1'b0;
    end
    else
    begin
      if (push)
        wp <= ~wp;
      if (pop)
        rp <= ~rp;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; valid guards every read
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp] <= in_s.data;
  end
endmodule

// ==== rtl/adb_board_ctrl.sv ====
// Purpose: Control of a six-channel sampling converter and dual output converter board
// Assumes: Host bus pins are asynchronous to core_clk_i; converter data lines are on core_clk_i
// Notes: Read data reaches the pins two to three cycles after the strobe
// Behaviour
// - Start edge holds samplers, starts conversion
// - Conversion-complete interrupt after 1.26 us
// - Starts never closer than 500 kHz
// - Own generator programmable 4 to 500 ksps
// - Start source: generator, trigger A/B, external
// - Drive cascade sample clock output
// - Reset loads both outputs with zero code
// - Output update trigger selectable, five choices
// - Interrupt while output converter accepts data
// - Input multiplexer offers four choices
// - Host reset input is active low
// - Both interrupt outputs are active low
// - Direction input low drives data hostward
// - Read data only with strobe and select
// - Write taken only with strobe and select
// - Two independent active-low chip selects
// - Data bus is sixteen lanes, bit 0 lowest
`timescale 1ns/100ps
`include "adb_map.svh"
module adb_board_ctrl
  import adb_pkg::*;
#(
  parameter int PW = 15,
  parameter int MAX_PERIOD = `ADB_MAX_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Host bus
  input wire logic host_reset_n_i,
  input wire logic select_first_n_i,
  input wire logic select_second_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic dir_to_host_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  output logic irq_first_n_o,
  output logic irq_second_n_o,
  // Trigger pins
  input wire logic host_trigger_in_a_i,
  input wire logic host_trigger_in_b_i,
  input wire logic ext_sample_clock_i,
  // Configuration
  input wire adb_start_src_t start_src_i,
  input wire adb_dac_trig_t dac_trig_i,
  input wire adb_mux_sel_t mux_sel_i,
  input wire logic [PW-1:0] sample_period_i,
  // Converter side
  input wire logic [95:0] adc_sample_i,
  output logic conversion_start_o,
  output logic cascade_sample_clock_out_o,
  output adb_mux_sel_t adc_mux_sel_o,
  output logic [15:0] dac_a_o,
  output logic [15:0] dac_b_o,
  output logic dac_load_o,
  output logic conv_busy_o
);
  localparam int AW = 28;
  localparam logic [PW-1:0] MIN_P = PW'(`ADB_MIN_PERIOD_CYC);
  localparam logic [PW-1:0] MAX_P = PW'(MAX_PERIOD);
  localparam logic [7:0] CONV_LAST = 8'(`ADB_CONV_CYC - 1);
  localparam logic [7:0] GAP_LAST = 8'(`ADB_MIN_PERIOD_CYC - 1);
  // Bit positions in the synchroniser vector
  localparam int B_RD = 0;
  localparam int B_WR = 1;
  localparam int B_S1 = 2;
  localparam int B_S2 = 3;
  localparam int B_HOST = 4;
  localparam int B_TA = 5;
  localparam int B_TB = 6;
  localparam int B_EXT = 7;
  localparam int B_RST = 8;
  localparam int B_ADDR = 9;
  localparam int B_DATA = 12;

  // Values that the logic cannot serve are refused at elaboration
  if (MAX_PERIOD < `ADB_MIN_PERIOD_CYC || MAX_PERIOD > (2 ** PW) - 1)
    $error("MAX_PERIOD out of range for PW");

  function automatic logic f_rise(input logic cur, input logic old);
    f_rise = cur & ~old;
  endfunction

  function automatic logic [PW-1:0] f_clamp(input logic [PW-1:0] p);
    if (p < MIN_P)
      f_clamp = MIN_P;
    else if (p > MAX_P)
      f_clamp = MAX_P;
    else
      f_clamp = p;
  endfunction

  logic [AW-1:0] raw;
  logic [AW-1:0] meta;
  logic [AW-1:0] syn;
  logic [AW-1:0] prev;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic wr_act_d;
  logic rd_start;
  logic wr_commit;
  logic srst;
  logic [2:0] wr_addr;
  logic [15:0] wr_data;
  logic [PW-1:0] gen_cnt;
  logic gen_tick;
  logic [7:0] gap_cnt;
  logic start_req;
  logic start_go;
  logic [7:0] conv_cnt;
  logic conv_done;
  logic eoc;
  logic [15:0] samp [6];
  logic upd_evt;
  logic upd_pend;
  logic push_valid;
  logic [16:0] push_data;

  adb_stream_if #(.W(17)) wr_s ();
  adb_stream_if #(.W(17)) dac_s ();

  // Active-low pins are turned round before the first stage
  assign raw = {data_i, addr_i, ~host_reset_n_i, ext_sample_clock_i, host_trigger_in_b_i,
                host_trigger_in_a_i, ~dir_to_host_n_i, ~select_second_n_i, ~select_first_n_i,
                ~wr_n_i, ~rd_n_i};

  // Two-stage synchroniser; only stage two and its delayed copy are read
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta <= '0;
      syn <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= raw;
      syn <= meta;
      prev <= syn;
    end
  end

  // Bus decode on synchronised pins
  assign srst = syn[B_RST];
  assign sel = syn[B_S1] | syn[B_S2];
  assign rd_act = syn[B_RD] & sel;
  assign wr_act = syn[B_WR] & sel;
  assign rd_start = rd_act & ~(prev[B_RD] & (prev[B_S1] | prev[B_S2]));
  assign wr_commit = wr_act_d & ~wr_act;

  // Write words are held while the strobe is low, since data may leave soon after it rises
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_act_d <= 1'b0;
      wr_addr <= 3'h0;
      wr_data <= 16'h0000;
    end
    else
    begin
      wr_act_d <= wr_act;
      if (wr_act)
      begin
        wr_addr <= syn[B_ADDR +: 3];
        wr_data <= syn[B_DATA +: 16];
      end
    end
  end

  // On-board sample clock generator, period in core cycles
  assign gen_tick = (start_src_i == ADB_SRC_OWN_CLOCK) && (gen_cnt == '0);
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      gen_cnt <= MAX_P;
    else if (srst || start_src_i != ADB_SRC_OWN_CLOCK || gen_cnt == '0)
      gen_cnt <= f_clamp(sample_period_i) - PW'(1);
    else
      gen_cnt <= gen_cnt - PW'(1);
  end

  // Start source selection
  always_comb
  begin
    unique case (start_src_i)
      ADB_SRC_OWN_CLOCK: start_req = gen_tick;
      ADB_SRC_TRIG_A: start_req = f_rise(syn[B_TA], prev[B_TA]);
      ADB_SRC_TRIG_B: start_req = f_rise(syn[B_TB], prev[B_TB]);
      ADB_SRC_EXT: start_req = f_rise(syn[B_EXT], prev[B_EXT]);
      default: start_req = 1'b0;
    endcase
  end

  // Starts closer than the least period are dropped, whatever their source
  assign start_go = start_req & (gap_cnt == GAP_LAST) & ~srst;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      gap_cnt <= GAP_LAST;
    else if (start_go)
      gap_cnt <= 8'h00;
    else if (gap_cnt != GAP_LAST)
      gap_cnt <= gap_cnt + 8'h01;
  end

  // Conversion timing; start line stays high for the whole conversion
  assign conv_done = conv_busy_o && (conv_cnt == 8'h00);
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      conv_busy_o <= 1'b0;
      conv_cnt <= 8'h00;
      conversion_start_o <= 1'b0;
      cascade_sample_clock_out_o <= 1'b0;
    end
    else if (srst)
    begin
      conv_busy_o <= 1'b0;
      conv_cnt <= 8'h00;
      conversion_start_o <= 1'b0;
      cascade_sample_clock_out_o <= 1'b0;
    end
    else if (start_go)
    begin
      conv_busy_o <= 1'b1;
      conv_cnt <= CONV_LAST;
      conversion_start_o <= 1'b1;
      cascade_sample_clock_out_o <= 1'b1;
    end
    else if (conv_done)
    begin
      conv_busy_o <= 1'b0;
      conversion_start_o <= 1'b0;
      cascade_sample_clock_out_o <= 1'b0;
    end
    else if (conv_busy_o)
      conv_cnt <= conv_cnt - 8'h01;
  end

  // Samples are taken at the end of conversion and overwritten by the next one
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < 6; i++)
        samp[i] <= 16'h0000;
    end
    else if (conv_done)
    begin
      for (int i = 0; i < 6; i++)
        samp[i] <= adc_sample_i[16*i +: 16];
    end
  end

  // Complete flag; a set wins over a read or start clear in the same cycle, host reset wins over both
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      eoc <= 1'b0;
    else if (srst)
      eoc <= 1'b0;
    else if (conv_done)
      eoc <= 1'b1;
    else if (start_go || (rd_start && syn[B_ADDR +: 3] == `ADB_RD_LAST_CH))
      eoc <= 1'b0;
  end

  // Read data and driver enable, both registered
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_o <= `ADB_DATA_IDLE;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_oe_o <= rd_act & syn[B_HOST];
      if (syn[B_ADDR +: 3] <= `ADB_RD_LAST_CH)
        data_o <= samp[syn[B_ADDR +: 3]];
      else if (syn[B_ADDR +: 3] == `ADB_RD_STATUS)
        data_o <= {13'h0000, wr_s.ready, conv_busy_o, eoc};
      else
        data_o <= `ADB_DATA_IDLE;
    end
  end

  // Output words enter the buffer; a write into a full buffer is dropped
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      push_valid <= 1'b0;
      push_data <= 17'h00000;
    end
    else
    begin
      push_valid <= wr_commit && !srst && (wr_addr == `ADB_WR_DAC_A || wr_addr == `ADB_WR_DAC_B);
      push_data <= {wr_addr[0], wr_data};
    end
  end
  assign wr_s.valid = push_valid & wr_s.ready;
  assign wr_s.data = push_data;

  adb_buf2 #(.W(17)) u_buf (
    .clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .clr_i(srst),
    .in_s(wr_s),
    .out_s(dac_s)
  );

  // Update trigger selection
  always_comb
  begin
    unique case (dac_trig_i)
      ADB_UPD_SYNC_ADC: upd_evt = conv_done;
      ADB_UPD_TRIG_A: upd_evt = f_rise(syn[B_TA], prev[B_TA]);
      ADB_UPD_TRIG_B: upd_evt = f_rise(syn[B_TB], prev[B_TB]);
      ADB_UPD_EXT: upd_evt = f_rise(syn[B_EXT], prev[B_EXT]);
      ADB_UPD_ON_WRITE: upd_evt = 1'b1;
      default: upd_evt = 1'b0;
    endcase
  end

  // A trigger drains every buffered word; without one the buffer stalls and fills
  assign dac_s.ready = upd_pend;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      upd_pend <= 1'b0;
    else if (srst)
      upd_pend <= 1'b0;
    else if (upd_evt)
      upd_pend <= 1'b1;
    // Pending ends only once the buffer is empty, so no word is left behind
    else if (!dac_s.valid)
      upd_pend <= 1'b0;
  end

  // Output codes start at zero after either reset
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dac_a_o <= `ADB_DAC_ZERO;
      dac_b_o <= `ADB_DAC_ZERO;
      dac_load_o <= 1'b0;
    end
    else if (srst)
    begin
      dac_a_o <= `ADB_DAC_ZERO;
      dac_b_o <= `ADB_DAC_ZERO;
      dac_load_o <= 1'b1;
    end
    else
    begin
      dac_load_o <= dac_s.valid & dac_s.ready;
      if (dac_s.valid && dac_s.ready && !dac_s.data[16])
        dac_a_o <= dac_s.data[15:0];
      if (dac_s.valid && dac_s.ready && dac_s.data[16])
        dac_b_o <= dac_s.data[15:0];
    end
  end

  // Active-low interrupts and multiplexer select, all registered
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_first_n_o <= 1'b1;
      irq_second_n_o <= 1'b1;
      adc_mux_sel_o <= ADB_MUX_INPUTS;
    end
    else
    begin
      irq_first_n_o <= ~eoc;
      irq_second_n_o <= ~wr_s.ready;
      adc_mux_sel_o <= mux_sel_i;
    end
  end
endmodule

// ==== tb/adb_ctrl_props.sv ====
// Purpose: Port checks of the converter board control
// Assumes: One core clock domain
// Notes: Bound to the top module by name
`timescale 1ns/100ps
module adb_ctrl_props
  import adb_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Host bus
  input wire logic select_first_n_i,
  input wire logic select_second_n_i,
  input wire logic rd_n_i,
  input wire logic dir_to_host_n_i,
  input wire logic data_oe_o,
  input wire logic irq_first_n_o,
  // Converter side
  input wire adb_mux_sel_t mux_sel_i,
  input wire adb_mux_sel_t adc_mux_sel_o,
  input wire logic conversion_start_o,
  input wire logic cascade_sample_clock_out_o
);
  logic [7:0] hi;
  logic [8:0] gap;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Width of the running start pulse
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
      hi <= 8'h00;
    else
      hi <= conversion_start_o ? hi + 8'h01 : 8'h00;
  // Cycles since the last start; saturates so long idles never wrap
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
      gap <= 9'h1ff;
    else if ($rose(conversion_start_o))
      gap <= 9'h000;
    else if (gap != 9'h1ff)
      gap <= gap + 9'h001;
  chk_read_needs_strobe:
    assert property ($rose(data_oe_o) |-> $past(!rd_n_i && !dir_to_host_n_i &&
      !(select_first_n_i && select_second_n_i), 2))
    else $error("lanes driven without read");
  chk_idle_releases:
    assert property (rd_n_i [*6] |-> !data_oe_o)
    else $error("lanes held after strobe");
  chk_dir_blocks:
    assert property (dir_to_host_n_i [*6] |-> !data_oe_o)
    else $error("lanes driven against direction");
  chk_start_width:
    assert property ($fell(conversion_start_o) |-> hi == 8'h9e)
    else $error("start pulse width wrong");
  chk_irq_after_end:
    assert property ($fell(conversion_start_o) |=> !irq_first_n_o)
    else $error("complete irq late");
  chk_start_spacing:
    assert property ($rose(conversion_start_o) |-> gap >= 9'h0f9)
    else $error("starts too close");
  chk_cascade_copy:
    assert property (cascade_sample_clock_out_o == conversion_start_o)
    else $error("cascade clock differs");
  chk_mux_follows:
    assert property ($past(rstn_i) |-> adc_mux_sel_o == $past(mux_sel_i))
    else $error("mux choice not passed");
endmodule
bind adb_board_ctrl adb_ctrl_props chk_u (.*);

// ==== tb/adb_host_model.sv ====
// Purpose: Host processor model on the asynchronous board bus
// Assumes: Read enable and data settle on the core clock
// Notes: Pins move on falling edges; released lanes show the inverse
`timescale 1ns/100ps
module adb_host_model
(
  // Clock
  input wire logic core_clk_i,
  // Lanes as seen on the wire
  input wire logic data_oe_i,
  input wire logic [15:0] data_i,
  // Pins toward the block
  output logic select_first_n_o,
  output logic select_second_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic dir_to_host_n_o,
  output logic [2:0] addr_o,
  output logic [15:0] data_o
);
  // Idle bus: strobes and selects high, lanes turned toward the block
  initial
  begin
    {select_second_n_o, select_first_n_o, rd_n_o, wr_n_o, dir_to_host_n_o} = 5'h1f;
    addr_o = 3'h0;
    data_o = 16'h0000;
  end
  // One access; a read holds until the block drives, eight cycles at most
  task automatic access(input logic [1:0] s, input logic dn, input logic w, input logic [2:0] a,
                        input logic [15:0] wd, output logic got, output logic [15:0] rdat);
    got = 1'b0;
    rdat = 16'h0000;
    @(negedge core_clk_i);
    {select_second_n_o, select_first_n_o} = s;
    addr_o = a;
    dir_to_host_n_o = dn;
    data_o = wd;
    if (w)
    begin
      wr_n_o = 1'b0;
      repeat (3) @(negedge core_clk_i);
    end
    else
    begin
      rd_n_o = 1'b0;
      for (int i = 0; i < 8 && !got; i++)
      begin
        @(negedge core_clk_i);
        got = (data_oe_i === 1'b1);
        rdat = data_i;
      end
    end
    {select_second_n_o, select_first_n_o, rd_n_o, wr_n_o, dir_to_host_n_o} = 5'h1f;
    data_o = ~data_o;
    repeat (6) @(negedge core_clk_i);
  endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench of the converter board control
// Assumes: Host model drives the bus; bench drives triggers and settings
// Notes: Generator ceiling cut to 400 cycles to keep the run short
`timescale 1ns/100ps
module testbench
  import adb_pkg::*;
;
  logic core_clk_i, rstn_i, host_reset_n_i, select_first_n_i, select_second_n_i, rd_n_i, wr_n_i, got;
  logic dir_to_host_n_i, data_oe_o, irq_first_n_o, irq_second_n_o, host_trigger_in_a_i, host_trigger_in_b_i;
  logic ext_sample_clock_i, conversion_start_o, cascade_sample_clock_out_o, dac_load_o, conv_busy_o;
  logic [2:0] addr_i;
  logic [15:0] data_o, host_d, dac_a_o, dac_b_o, rd, ea;
  logic [14:0] sample_period_i;
  logic [95:0] adc_sample_i;
  adb_start_src_t start_src_i;
  adb_dac_trig_t dac_trig_i;
  adb_mux_sel_t mux_sel_i, adc_mux_sel_o;
  int fails, cmp_count, starts, n, n1;
  logic [14:0] per[3] = '{15'h012c, 15'h0064, 15'h7fff};
  logic [15:0] pexp[3] = '{16'h012c, 16'h00fa, 16'h0190};
  // Wire level of the shared lanes
  wire [15:0] data_i = data_oe_o ? data_o : host_d;
  wire [1:0] mon = {irq_first_n_o, conversion_start_o};
  // Core clock, 8 ns period
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Starts seen at the pin
  always @(posedge conversion_start_o)
    starts++;
  adb_board_ctrl #(.PW(15), .MAX_PERIOD(400)) dut_u (.*);
  adb_host_model host_u (.core_clk_i(core_clk_i), .data_oe_i(data_oe_o), .data_i(data_i),
    .select_first_n_o(select_first_n_i), .select_second_n_o(select_second_n_i), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .dir_to_host_n_o(dir_to_host_n_i), .addr_o(addr_i), .data_o(host_d));
  task automatic check16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bounded wait for a level on start (0) or complete irq (1)
  task automatic wait_lvl(input int w, input logic v, input int lim, output int k);
    for (k = 0; mon[w] !== v; k++)
    begin
      if (k == lim)
      begin
        check16(16'h0000, 16'h0001);
        summarize();
      end
      @(negedge core_clk_i);
    end
  endtask
  task automatic rdc(input logic [1:0] s, input logic dn, input logic [2:0] a, input logic g, input logic [15:0] e);
    host_u.access(s, dn, 1'b0, a, 16'h0000, got, rd);
    check16({15'h0000, got}, {15'h0000, g});
    if (g)
      check16(rd, e);
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [15:0] d);
    host_u.access(s, 1'b1, 1'b1, a, d, got, rd);
    repeat (4) @(negedge core_clk_i);
  endtask
  // Trigger pin k high for three cycles, long enough to pass the synchroniser
  task automatic pulse(input int k);
    @(negedge core_clk_i);
    {ext_sample_clock_i, host_trigger_in_b_i, host_trigger_in_a_i} = 3'(3'h1 << k);
    repeat (3) @(negedge core_clk_i);
    {ext_sample_clock_i, host_trigger_in_b_i, host_trigger_in_a_i} = 3'h0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rstn_i, host_reset_n_i, host_trigger_in_a_i, host_trigger_in_b_i, ext_sample_clock_i} = 5'h08;
    start_src_i = ADB_SRC_TRIG_A;
    dac_trig_i = ADB_UPD_ON_WRITE;
    mux_sel_i = ADB_MUX_INPUTS;
    sample_period_i = 15'h012c;
    adc_sample_i = 96'h6666_5555_4444_3333_2222_1111;
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check16(dac_a_o, 16'h0000);
    check16(dac_b_o, 16'h0000);
    check16({14'h0000, irq_first_n_o, irq_second_n_o}, 16'h0002);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      mux_sel_i = adb_mux_sel_t'(m);
      repeat (2) @(negedge core_clk_i);
      check16({14'h0000, adc_mux_sel_o}, 16'(m));
    end
    $display("test mux done");
    pulse(1);
    pulse(2);
    repeat (10) @(negedge core_clk_i);
    check16(16'(starts), 16'h0000);
    pulse(0);
    wait_lvl(0, 1'b1, 10, n);
    check16({15'h0000, conv_busy_o}, 16'h0001);
    wait_lvl(1, 1'b0, 200, n);
    check16(16'(n), 16'h009f);
    rdc(2'b10, 1'b0, 3'h6, 1'b1, 16'h0005);
    for (int c = 0; c < 6; c++)
      rdc({c[0], ~c[0]}, 1'b0, 3'(c), 1'b1, 16'(16'h1111 * (c + 1)));
    check16({15'h0000, irq_first_n_o}, 16'h0001);
    rdc(2'b01, 1'b0, 3'h6, 1'b1, 16'h0004);
    rdc(2'b11, 1'b0, 3'h0, 1'b0, 16'h0000);
    rdc(2'b10, 1'b1, 3'h0, 1'b0, 16'h0000);
    rdc(2'b01, 1'b0, 3'h7, 1'b1, 16'h0000);
    $display("test conversion done");
    repeat (100) @(negedge core_clk_i);
    n1 = starts;
    pulse(0);
    repeat (100) @(negedge core_clk_i);
    pulse(0);
    repeat (300) @(negedge core_clk_i);
    check16(16'(starts - n1), 16'h0001);
    for (int s = 2; s < 4; s++)
    begin
      start_src_i = adb_start_src_t'(s);
      pulse(s - 1);
      wait_lvl(0, 1'b1, 10, n);
      repeat (300) @(negedge core_clk_i);
    end
    $display("test sources done");
    start_src_i = ADB_SRC_OWN_CLOCK;
    for (int i = 0; i < 3; i++)
    begin
      sample_period_i = per[i];
      wait_lvl(0, 1'b0, 500, n);
      wait_lvl(0, 1'b1, 500, n);
      wait_lvl(0, 1'b0, 500, n);
      wait_lvl(0, 1'b1, 500, n1);
      check16(16'(n + n1), pexp[i]);
    end
    start_src_i = ADB_SRC_TRIG_A;
    $display("test generator done");
    wr(2'b10, 3'h0, 16'h1234);
    wr(2'b01, 3'h1, 16'h8765);
    wr(2'b10, 3'h3, 16'hffff);
    wr(2'b11, 3'h0, 16'hffff);
    check16(dac_a_o, 16'h1234);
    check16(dac_b_o, 16'h8765);
    ea = 16'h1234;
    for (int t = 1; t < 4; t++)
    begin
      dac_trig_i = adb_dac_trig_t'(t);
      wr(2'b10, 3'h0, 16'(t));
      wr(2'b10, 3'h0, 16'(t + 16));
      check16({15'h0000, irq_second_n_o}, 16'h0001);
      wr(2'b10, 3'h0, 16'hffff);
      check16(dac_a_o, ea);
      pulse(t - 1);
      repeat (8) @(negedge core_clk_i);
      ea = 16'(t + 16);
      check16(dac_a_o, ea);
      check16({15'h0000, irq_second_n_o}, 16'h0000);
    end
    dac_trig_i = ADB_UPD_SYNC_ADC;
    repeat (300) @(negedge core_clk_i);
    rdc(2'b10, 1'b0, 3'h5, 1'b1, 16'h6666);
    wr(2'b01, 3'h1, 16'h5a5a);
    check16(dac_b_o, 16'h8765);
    pulse(0);
    wait_lvl(1, 1'b0, 200, n);
    repeat (4) @(negedge core_clk_i);
    check16(dac_b_o, 16'h5a5a);
    $display("test output update done");
    host_reset_n_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check16({15'h0000, dac_load_o}, 16'h0001);
    host_reset_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check16(dac_a_o, 16'h0000);
    check16(dac_b_o, 16'h0000);
    $display("test host reset done");
    summarize();
  end
endmodule
